// File: hw/fpas_cfg.svh
// Contract
// - Fullword add adds second operand to first-field register, writes 32-bit sum back.
// - Fullword add opcodes: 5A indexed, 0A reg-reg, FA 32-bit immediate, 26 short.
// - Short forms zero-extend the 4-bit nibble to a 32-bit operand.
// - 32-bit immediate operand is index register plus immediate field.
// - Halfword add/subtract sign-extend the 16-bit operand to 32 bits.
// - 16-bit immediate is sign-extended, then index register added.
// - Halfword add opcodes: 4A indexed, CA 16-bit immediate; result to first register.
// - Opcode 51 adds register to memory word, writes memory; register unchanged.
// - Opcode 61 adds memory halfword to register low half; stores 16-bit sum.
// - Halfword-to-storage flags come from the 16-bit result.
// - No overflow: V clear, L for negative, G for positive, none for zero.
// - V on signed overflow, C on carry, independent; G and L then undefined.
// - Fullword subtract takes second operand from first register, writes it back.
// - Fullword subtract opcodes: 5B indexed, 0B reg-reg, FB 32-bit immediate, 27 short.
// - Subtract reports borrow in the carry position; other flags as add.
// - Halfword subtract opcodes: 4B indexed, CB 16-bit immediate, sign-extended operand.
// - Overflow means the signed result does not fit 31 magnitude bits plus sign.
// - Carry means the unsigned sum needs a 33rd bit.
`ifndef FPAS_CFG_SVH
`define FPAS_CFG_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define FPAS_OP_A_RX 8'h5A
`define FPAS_OP_A_RR 8'h0A
`define FPAS_OP_A_RI2 8'hFA
`define FPAS_OP_A_SF 8'h26
`define FPAS_OP_S_RX 8'h5B
`define FPAS_OP_S_RR 8'h0B
`define FPAS_OP_S_RI2 8'hFB
`define FPAS_OP_S_SF 8'h27
`define FPAS_OP_AH_RX 8'h4A
`define FPAS_OP_AH_RI1 8'hCA
`define FPAS_OP_SH_RX 8'h4B
`define FPAS_OP_SH_RI1 8'hCB
`define FPAS_OP_AM_RX 8'h51
`define FPAS_OP_AHM_RX 8'h61

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FPAS_CC_RST 4'h0
`define FPAS_WORD_RST 32'h0000_0000
`define FPAS_REG_RST 4'h0

// ----------------------------------------
// Condition code bit positions (C V G L, C is msb)
// ----------------------------------------
`define FPAS_CC_C 3
`define FPAS_CC_V 2
`define FPAS_CC_G 1
`define FPAS_CC_L 0

`endif

// File: hw/fpas_pkg.sv
package fpas_pkg;

   // ----------------------------------------
   // Operand source kinds
   // ----------------------------------------
   typedef enum logic [2:0] {
      FPAS_SRC_REG = 3'h0, // reg_reg_format
      FPAS_SRC_MEMW = 3'h1, // fullword storage operand
      FPAS_SRC_MEMH = 3'h2, // halfword storage operand
      FPAS_SRC_IMM32 = 3'h3, // immediate_format_32bit
      FPAS_SRC_IMM16 = 3'h4, // immediate_format_16bit
      FPAS_SRC_NIB = 3'h5 // short_format
   } fpas_src_t;

   // Destination kinds
   typedef enum logic [1:0] {
      FPAS_DST_REG = 2'h0,
      FPAS_DST_MEMW = 2'h1,
      FPAS_DST_MEMH = 2'h2
   } fpas_dst_t;

   // Decoded operation
   typedef struct packed {
      logic legal;
      logic sub;
      fpas_src_t src;
      fpas_dst_t dst;
   } fpas_dec_t;

   // Instruction as handed over by the decoder
   typedef struct packed {
      logic [7:0] opcode;
      logic [3:0] first_reg_field;
      logic [3:0] second_reg_field;
      logic [31:0] immediate_field;
      logic [31:0] mem_data;
   } fpas_req_t;

   // Completed result
   typedef struct packed {
      logic reg_we;
      logic [3:0] reg_addr;
      logic mem_we;
      logic mem_half;
      logic [31:0] data;
      logic [3:0] cc;
   } fpas_rsp_t;

endpackage : fpas_pkg

// File: hw/fpas_regfile.sv
`timescale 1ns/10ps
`include "fpas_cfg.svh"

// Register file with two registered read ports and one write port
module fpas_regfile
   import fpas_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Read ports
   input wire logic [AW-1:0] ra_addr,
   input wire logic [AW-1:0] rb_addr,
   output logic [WIDTH-1:0] ra_data,
   output logic [WIDTH-1:0] rb_data,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] wa_addr,
   input wire logic [WIDTH-1:0] wa_data
);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [WIDTH-1:0] ra_d;
   logic [WIDTH-1:0] rb_d;

   // Next contents and read data
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_d[i] = mem_q[i];
      end
      if (we) begin
         mem_d[wa_addr] = wa_data;
      end
      ra_d = mem_q[ra_addr];
      rb_d = mem_q[rb_addr];
   end

   // Registers are cleared so the datapath never reads unknowns
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         ra_data <= '0;
         rb_data <= '0;
      end else begin
         mem_q <= mem_d;
         ra_data <= ra_d;
         rb_data <= rb_d;
      end
   end

endmodule : fpas_regfile

// File: hw/fpas_core.sv
`timescale 1ns/10ps
`include "fpas_cfg.svh"

// Fixed point add/subtract datapath with general registers and condition code
module fpas_core
   import fpas_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int NREGS = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Instruction request from the decoder
   input wire logic req_valid,
   input wire fpas_req_t req,
   output logic req_ready,
   // Completion
   output logic done,
   output logic illegal,
   output logic [WIDTH-1:0] result,
   output logic [3:0] cc,
   // Register write echo
   output logic reg_we,
   output logic [3:0] reg_addr,
   // Storage write-back
   output logic mem_we,
   output logic mem_half,
   output logic [WIDTH-1:0] mem_wdata,
   // Register preload path
   input wire logic load_we,
   input wire logic [3:0] load_addr,
   input wire logic [WIDTH-1:0] load_data
);

   // ----------------------------------------
   // Reset synchroniser
   // ----------------------------------------
   logic rst_meta_q;
   logic rst_n;

   // Release through two flops so every register leaves reset together
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   function automatic fpas_dec_t decode(input logic [7:0] op);
      fpas_dec_t d;
      d = '{legal: 1'b1, sub: 1'b0, src: FPAS_SRC_REG, dst: FPAS_DST_REG};
      case (op)
         `FPAS_OP_A_RX: d.src = FPAS_SRC_MEMW;
         `FPAS_OP_A_RR: d.src = FPAS_SRC_REG;
         `FPAS_OP_A_RI2: d.src = FPAS_SRC_IMM32;
         `FPAS_OP_A_SF: d.src = FPAS_SRC_NIB;
         `FPAS_OP_S_RX: begin
            d.src = FPAS_SRC_MEMW;
            d.sub = 1'b1;
         end
         `FPAS_OP_S_RR: d.sub = 1'b1;
         `FPAS_OP_S_RI2: begin
            d.src = FPAS_SRC_IMM32;
            d.sub = 1'b1;
         end
         `FPAS_OP_S_SF: begin
            d.src = FPAS_SRC_NIB;
            d.sub = 1'b1;
         end
         `FPAS_OP_AH_RX: d.src = FPAS_SRC_MEMH;
         `FPAS_OP_AH_RI1: d.src = FPAS_SRC_IMM16;
         `FPAS_OP_SH_RX: begin
            d.src = FPAS_SRC_MEMH;
            d.sub = 1'b1;
         end
         `FPAS_OP_SH_RI1: begin
            d.src = FPAS_SRC_IMM16;
            d.sub = 1'b1;
         end
         `FPAS_OP_AM_RX: begin
            d.src = FPAS_SRC_MEMW;
            d.dst = FPAS_DST_MEMW;
         end
         `FPAS_OP_AHM_RX: begin
            d.src = FPAS_SRC_MEMH;
            d.dst = FPAS_DST_MEMH;
         end
         default: d.legal = 1'b0;
      endcase
      return d;
   endfunction : decode

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   typedef enum logic [1:0] {
      FPAS_ST_IDLE = 2'b00,
      FPAS_ST_READ = 2'b01,
      FPAS_ST_EXEC = 2'b10
   } fpas_state_t;

   fpas_state_t state_q;
   fpas_state_t state_d;
   fpas_req_t req_q;
   fpas_req_t req_d;
   fpas_dec_t dec;
   logic [WIDTH-1:0] ra_data;
   logic [WIDTH-1:0] rb_data;
   logic [3:0] rb_sel;

   assign dec = decode(req_q.opcode);
   // Index field shares the second register field position; the read uses the
   // captured copy because the decoder may drop its request after the take
   assign rb_sel = req_q.second_reg_field;
   // Only one instruction is in flight; the decoder waits on ready
   assign req_ready = (state_q == FPAS_ST_IDLE);

   // Next state and captured instruction
   always_comb begin
      state_d = state_q;
      req_d = req_q;
      case (state_q)
         FPAS_ST_IDLE: begin
            if (req_valid) begin
               req_d = req;
               state_d = FPAS_ST_READ;
            end
         end
         FPAS_ST_READ: state_d = FPAS_ST_EXEC;
         FPAS_ST_EXEC: state_d = FPAS_ST_IDLE;
         default: state_d = FPAS_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= FPAS_ST_IDLE;
         req_q <= '0;
      end else begin
         state_q <= state_d;
         req_q <= req_d;
      end
   end

   // ----------------------------------------
   // Operand expansion and arithmetic
   // ----------------------------------------
   logic [WIDTH-1:0] op1;
   logic [WIDTH-1:0] op2;
   logic [WIDTH:0] sum33;
   logic [15:0] sum16;
   logic [16:0] sum17;
   logic [3:0] cc_calc;
   logic [WIDTH-1:0] res_calc;
   logic [3:0] x_sel;

   // Index register zero means no indexing, as in other indexed forms
   assign x_sel = req_q.second_reg_field;

   always_comb begin
      op1 = ra_data;
      op2 = rb_data;
      case (dec.src)
         FPAS_SRC_REG: op2 = rb_data;
         FPAS_SRC_MEMW: op2 = req_q.mem_data;
         FPAS_SRC_MEMH: op2 = {{16{req_q.mem_data[15]}}, req_q.mem_data[15:0]};
         FPAS_SRC_IMM32: op2 = req_q.immediate_field + ((x_sel != 4'h0) ? rb_data : '0);
         FPAS_SRC_IMM16: op2 = {{16{req_q.immediate_field[15]}}, req_q.immediate_field[15:0]}
                              + ((x_sel != 4'h0) ? rb_data : '0);
         FPAS_SRC_NIB: op2 = {28'h000_0000, req_q.second_reg_field};
         default: op2 = rb_data;
      endcase
   end

   // Word add or subtract, or 16-bit add for halfword to storage; flags from the width that holds the result
   always_comb begin
      sum33 = '0;
      sum17 = '0;
      sum16 = '0;
      cc_calc = `FPAS_CC_RST;
      res_calc = '0;
      if (dec.dst == FPAS_DST_MEMH) begin
         // Halfword to storage: 16-bit sum against register low half
         sum17 = {1'b0, op2[15:0]} + {1'b0, op1[15:0]};
         sum16 = sum17[15:0];
         res_calc = {16'h0000, sum16};
         cc_calc[`FPAS_CC_C] = sum17[16];
         cc_calc[`FPAS_CC_V] = (op1[15] == op2[15]) && (sum16[15] != op1[15]);
         cc_calc[`FPAS_CC_L] = sum16[15];
         cc_calc[`FPAS_CC_G] = !sum16[15] && (sum16 != 16'h0000);
      end else begin
         if (dec.sub) begin
            sum33 = {1'b0, op1} - {1'b0, op2};
            cc_calc[`FPAS_CC_C] = (op1 < op2);
            cc_calc[`FPAS_CC_V] = (op1[31] != op2[31]) && (sum33[31] != op1[31]);
         end else begin
            sum33 = {1'b0, op1} + {1'b0, op2};
            cc_calc[`FPAS_CC_C] = sum33[32];
            cc_calc[`FPAS_CC_V] = (op1[31] == op2[31]) && (sum33[31] != op1[31]);
         end
         res_calc = sum33[31:0];
         // G and L follow the stored sign even on overflow, which software ignores
         cc_calc[`FPAS_CC_L] = res_calc[31];
         cc_calc[`FPAS_CC_G] = !res_calc[31] && (res_calc != '0);
      end
   end

   // ----------------------------------------
   // Completion and write-back
   // ----------------------------------------
   logic exec;
   fpas_rsp_t rsp_d;
   fpas_rsp_t rsp_q;
   logic done_d;
   logic done_q;
   logic ill_d;
   logic ill_q;

   assign exec = (state_q == FPAS_ST_EXEC);

   always_comb begin
      rsp_d = rsp_q;
      rsp_d.reg_we = 1'b0;
      rsp_d.mem_we = 1'b0;
      done_d = 1'b0;
      ill_d = 1'b0;
      if (exec) begin
         done_d = 1'b1;
         ill_d = !dec.legal;
         if (dec.legal) begin
            rsp_d.data = res_calc;
            rsp_d.cc = cc_calc;
            rsp_d.reg_addr = req_q.first_reg_field;
            rsp_d.reg_we = (dec.dst == FPAS_DST_REG);
            rsp_d.mem_we = (dec.dst != FPAS_DST_REG);
            rsp_d.mem_half = (dec.dst == FPAS_DST_MEMH);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_q <= '{reg_we: 1'b0, reg_addr: `FPAS_REG_RST, mem_we: 1'b0, mem_half: 1'b0,
                    data: `FPAS_WORD_RST, cc: `FPAS_CC_RST};
         done_q <= 1'b0;
         ill_q <= 1'b0;
      end else begin
         rsp_q <= rsp_d;
         done_q <= done_d;
         ill_q <= ill_d;
      end
   end

   // Register file: preload port wins only when no result is written
   logic rf_we;
   logic [3:0] rf_wa;
   logic [WIDTH-1:0] rf_wd;

   always_comb begin
      rf_we = load_we;
      rf_wa = load_addr;
      rf_wd = load_data;
      if (rsp_q.reg_we) begin
         rf_we = 1'b1;
         rf_wa = rsp_q.reg_addr;
         rf_wd = rsp_q.data;
      end
   end

   fpas_regfile #(
      .WIDTH(WIDTH),
      .DEPTH(NREGS),
      .AW(4)
   ) u_regs (
      .clk(clk),
      .rst_n(rst_n),
      .ra_addr(req_q.first_reg_field),
      .rb_addr(rb_sel),
      .ra_data(ra_data),
      .rb_data(rb_data),
      .we(rf_we),
      .wa_addr(rf_wa),
      .wa_data(rf_wd)
   );

   // Outputs
   assign done = done_q;
   assign illegal = ill_q;
   assign result = rsp_q.data;
   assign cc = rsp_q.cc;
   assign reg_we = rsp_q.reg_we;
   assign reg_addr = rsp_q.reg_addr;
   assign mem_we = rsp_q.mem_we;
   assign mem_half = rsp_q.mem_half;
   assign mem_wdata = rsp_q.data;

endmodule : fpas_core

// File: verif/fpas_core_monitor.sv
`timescale 1ns/10ps
module fpas_core_monitor
   import fpas_pkg::*;
#(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Handshake
   input wire logic req_valid,
   input wire logic req_ready,
   // Completion
   input wire logic done,
   input wire logic illegal,
   input wire logic [WIDTH-1:0] result,
   input wire logic [3:0] cc,
   input wire logic reg_we,
   input wire logic mem_we,
   input wire logic mem_half,
   input wire logic [WIDTH-1:0] mem_wdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ----------------------------------------
   // Handshake and completion
   // ----------------------------------------
   logic take;
   logic ok;
   // Accepted request, legal completion
   assign take = req_valid && req_ready;
   assign ok = done && !illegal;
   done_after_take_a: assert property (take |-> ##3 done)
      else $error("done missing three cycles after take");
   done_has_cause_a: assert property (done |-> $past(take, 3))
      else $error("done without a taken request");
   busy_refuse_a: assert property (take |=> !req_ready [*2] ##1 req_ready)
      else $error("ready wrong while busy");
   illegal_quiet_a: assert property (illegal |-> done && !reg_we && !mem_we)
      else $error("illegal op wrote a result");
   one_dest_a: assert property (ok |-> reg_we ^ mem_we)
      else $error("legal op without exactly one destination");
   store_data_a: assert property (mem_we |-> done && mem_wdata == result)
      else $error("store data differs from result");
   half_store_a: assert property (mem_we && mem_half |-> result[31:16] == 16'h0000)
      else $error("halfword store with upper bits set");
   state_hold_a: assert property (!ok |-> $stable(cc) && $stable(result))
      else $error("flags or result moved without completion");
   flags_word_a: assert property (ok && !cc[2] && !mem_half |->
      cc[1:0] == {!result[31] && result != 0, result[31]})
      else $error("word G or L flag wrong");
   flags_half_a: assert property (ok && !cc[2] && mem_half |->
      cc[1:0] == {!result[15] && result[15:0] != 0, result[15]})
      else $error("halfword G or L flag wrong");
   // Main scenarios
   cov_reg_c: cover property (ok && reg_we);
   cov_mem_c: cover property (ok && mem_we && mem_half);
   cov_ovf_c: cover property (ok && cc[2]);
   cov_bad_c: cover property (illegal);
endmodule : fpas_core_monitor

bind fpas_core fpas_core_monitor #(.WIDTH(WIDTH)) u_mon (
   .clk(clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
   .done(done), .illegal(illegal), .result(result), .cc(cc), .reg_we(reg_we),
   .mem_we(mem_we), .mem_half(mem_half), .mem_wdata(mem_wdata)
);

// File: verif/fpas_dec_model.sv
`timescale 1ns/10ps
module fpas_dec_model
   import fpas_pkg::*;
(
   // Clock
   input wire logic clk,
   // Request toward the core
   output logic req_valid,
   output fpas_req_t req,
   input wire logic req_ready
);
   // ----------------------------------------
   // Issue path
   // ----------------------------------------
   initial begin
      req_valid = 1'b0;
      req = '0;
   end
   // Operands come aligned, a halfword in bits 15:0
   // Released fields show the inverse so stale data never looks valid
   task automatic issue(input fpas_req_t c, input int gap);
      int n;
      repeat (gap) begin
         @(posedge clk);
         #1;
      end
      req = c;
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      req = ~c;
   endtask : issue
endmodule : fpas_dec_model

// File: verif/fpas_core_tb.sv
`timescale 1ns/10ps
module fpas_core_tb
   import fpas_pkg::*;
;
   logic clk, resetn, req_valid, req_ready, done, illegal, reg_we, mem_we, mem_half, load_we;
   fpas_req_t req;
   logic [31:0] result, mem_wdata, load_data;
   logic [3:0] cc, reg_addr, load_addr;
   logic [31:0] regs [16];
   int mismatches, checks_done;
   // Every handled opcode plus one unhandled
   logic [7:0] ops [15] = '{8'h5A, 8'h0A, 8'hFA, 8'h26, 8'h5B, 8'h0B, 8'hFB, 8'h27,
      8'h4A, 8'hCA, 8'h4B, 8'hCB, 8'h51, 8'h61, 8'h59};
   // Known cases: op, register, storage, result, flags
   logic [107:0] corner [11] = '{
      {8'h5A, 32'h7F341234, 32'h7F124321, 32'hFE465555, 4'h5},
      {8'h5A, 32'h80000001, 32'h80000002, 32'h00000003, 4'hE},
      {8'h4A, 32'h00230002, 32'h0000FFFF, 32'h00230001, 4'hA},
      {8'h4A, 32'hFFFFFFF5, 32'h0000FFF2, 32'hFFFFFFE7, 4'h9},
      {8'h61, 32'h00230002, 32'h0000FFFF, 32'h00000001, 4'hA},
      {8'h61, 32'hFFFFFFF5, 32'h0000FFF2, 32'h0000FFE7, 4'h9},
      {8'h5B, 32'h44444444, 32'h44444444, 32'h00000000, 4'h0},
      {8'h5B, 32'h23456789, 32'hFFFF4321, 32'h23462468, 4'hA},
      {8'h4B, 32'h00123456, 32'h0000FFF4, 32'h00123462, 4'hA},
      {8'h4B, 32'hFFFF4567, 32'h00002345, 32'hFFFF2222, 4'h1},
      {8'h51, 32'h00000008, 32'h034289AB, 32'h034289B3, 4'h2}};

   fpas_core u_dut (
      .clk(clk), .resetn(resetn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .done(done), .illegal(illegal), .result(result), .cc(cc), .reg_we(reg_we),
      .reg_addr(reg_addr), .mem_we(mem_we), .mem_half(mem_half), .mem_wdata(mem_wdata),
      .load_we(load_we), .load_addr(load_addr), .load_data(load_data)
   );
   fpas_dec_model u_dec (.clk(clk), .req_valid(req_valid), .req(req), .req_ready(req_ready));

   // ----------------------------------------
   // Clock, compare, verdict
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict

   // ----------------------------------------
   // Reference arithmetic
   // ----------------------------------------
   // dst: 0 register, 1 storage word, 2 storage halfword
   function automatic void expect_op(input logic [7:0] op, input logic [31:0] a, b2, x, imm, m,
      input logic [3:0] nib, output logic [31:0] r, output logic [3:0] f,
      output logic [1:0] dst);
      logic [31:0] b;
      logic [32:0] s;
      logic sub;
      sub = op inside {8'h5B, 8'h0B, 8'hFB, 8'h27, 8'h4B, 8'hCB};
      case (op)
         8'h0A, 8'h0B: b = b2;
         8'hFA, 8'hFB: b = x + imm;
         8'h26, 8'h27: b = {28'h0000000, nib};
         8'h4A, 8'h4B: b = {{16{m[15]}}, m[15:0]};
         8'hCA, 8'hCB: b = {{16{imm[15]}}, imm[15:0]} + x;
         default: b = m;
      endcase
      if (op == 8'h61) begin
         s = {16'h0000, a[15:0]} + {16'h0000, m[15:0]};
         r = {16'h0000, s[15:0]};
         f = {s[16], a[15] == m[15] && s[15] != a[15], !s[15] && s[15:0] != 0, s[15]};
         dst = 2'h2;
      end else begin
         s = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
         r = s[31:0];
         f = {s[32], a[31] == (b[31] ^ sub) && s[31] != a[31], !s[31] && r != 0, s[31]};
         dst = {1'b0, op == 8'h51};
      end
   endfunction : expect_op

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task automatic load(input logic [3:0] a, input logic [31:0] d);
      load_we = 1'b1;
      load_addr = a;
      load_data = d;
      @(posedge clk);
      #1;
      load_we = 1'b0;
      regs[a] = d;
      // Let an edge pass so a following load never re-raises the strobe at once
      @(posedge clk);
      #1;
   endtask : load
   // One instruction, then an idle cycle so the write-back lands before the next read
   task automatic run(input logic [7:0] op, input logic [3:0] r1, r2, input logic [31:0] imm, m);
      logic [31:0] r;
      logic [3:0] f, keep, mask;
      logic [1:0] dst;
      int n;
      expect_op(op, regs[r1], regs[r2], r2 == 4'h0 ? 32'h0 : regs[r2], imm, m, r2, r, f, dst);
      keep = cc;
      u_dec.issue('{op, r1, r2, imm, m}, $urandom_range(2));
      n = 0;
      while (done !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("done", {31'h0, done}, 32'h1);
      if (done !== 1'b1) print_verdict();
      mask = f[2] ? 4'hC : 4'hF;
      if (op == 8'h59) begin
         check("illegal", {31'h0, illegal}, 32'h1);
         check("cc kept", {28'h0, cc}, {28'h0, keep});
      end else begin
         check("result", result, r);
         check("cc", {28'h0, cc & mask}, {28'h0, f & mask});
         check("dest", {29'h0, reg_we, mem_we, mem_half}, {29'h0, dst == 0, dst != 0, dst == 2});
         if (dst == 2'h0) check("reg_addr", {28'h0, reg_addr}, {28'h0, r1});
         if (dst != 2'h0) check("mem_wdata", mem_wdata, r);
         if (dst == 2'h0) regs[r1] = r;
      end
      @(posedge clk);
      #1;
   endtask : run

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'hB94B2F65));
      resetn = 1'b0;
      load_we = 1'b0;
      load_addr = 4'h0;
      load_data = 32'h0;
      mismatches = 0;
      checks_done = 0;
      repeat (12) @(posedge clk);
      #1;
      resetn = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      for (int i = 0; i < 16; i++) load(i[3:0], $urandom);
      // Known operand pairs with exact results and flags
      foreach (corner[i]) begin
         load(4'h1, corner[i][99:68]);
         run(corner[i][107:100], 4'h1, 4'h0, 32'h0, corner[i][67:36]);
         check("known result", result, corner[i][35:4]);
         check("known cc", {28'h0, cc}, {28'h0, corner[i][3:0]});
      end
      // Random traffic over every opcode with boundary operands mixed in
      for (int i = 0; i < 90; i++) begin
         if (i % 7 == 3) load(4'($urandom), ($urandom_range(1) == 0) ? 32'h7FFFFFFF : 32'h80000000);
         run(ops[i % 15], 4'($urandom), 4'($urandom), $urandom,
            ($urandom_range(3) == 0) ? 32'hFFFF : $urandom);
      end
      print_verdict();
   end
endmodule : fpas_core_tb
